/* File: src/fpcp_defs.vh */
// Constants for the flash program command port
// What this block does
// [RULE1] Enable command must open every session
// [RULE2] Parallel command: select low, AAh, opcode
// [RULE3] Opcode 32h reads user signature row
// [RULE4] Opcode 38h reads maker signature row
// [RULE5] Offset from low five bits, wraps
// [RULE6] Read data driven after fourth strobe fall
// [RULE7] Programmer releases data port before then
// [RULE8] Each further strobe advances to next byte
// [RULE9] Opcode E4h writes lock bits, 4 ms
// [RULE10] Opcode 64h reads lock bits
// [RULE11] Opcode E1h writes user fuses, 4 ms
// [RULE12] Programmer writes unimplemented fuse bits one
// [RULE13] Opcode 61h reads user fuses
// [RULE14] Opcode 60h reads status byte
// [RULE15] Serial link takes the same commands
// [RULE16] Serial needs fuse, change after power cycle; reset here reloads the fuses to FFh, so the link stays off
// [RULE17] Serial link cannot re-enable serial fuse
// [RULE18] Serial bytes move MSB first
// [RULE19] Output on SCK fall, sample on rise
// [RULE20] Serial command completes on SS rising
// [RULE21] Programmer serial entry order
// [RULE22] Programmer serial exit order
// [RULE23] Programmer waits 2 ms after power-up; the bench opens the session 6 clocks after reset
// [RULE24] Busy low during nonvolatile write cycle
// [RULE25] Unknown opcode ignored, no state change
`ifndef FPCP_DEFS_VH
`define FPCP_DEFS_VH
`define FPCP_PREAMBLE   8'hAA
`define FPCP_EN1        8'hAC
`define FPCP_EN2        8'h53
`define FPCP_OP_USIG    8'h32
`define FPCP_OP_MSIG    8'h38
`define FPCP_OP_WLOCK   8'hE4
`define FPCP_OP_RLOCK   8'h64
`define FPCP_OP_WFUSE   8'hE1
`define FPCP_OP_RFUSE   8'h61
`define FPCP_OP_STAT    8'h60
`define FPCP_FUSE_RST   8'hFF
`define FPCP_LOCK_RST   8'hFF
`define FPCP_SERFUSE_B  0
`define FPCP_LOCK_MASK  8'h03
`define FPCP_WR_MS      4
`define FPCP_CLK_KHZ    25000
`define FPCP_STAT_BUSY  0
`endif

/* File: src/fpcp_port.v */
// Flash program command port: parallel and serial command decode
`timescale 1ns/1ps
`include "fpcp_defs.vh"
module fpcp_port #(
	parameter WR_CYCLES = `FPCP_WR_MS * `FPCP_CLK_KHZ,
	parameter SIG_W     = 8
) (
	input  wire         i_clock,
	input  wire         i_reset_n,
	input  wire         i_prog_session,
	input  wire         i_select_pin_n,
	input  wire         i_parallel_strobe,
	input  wire [7:0]   i_parallel_data_port,
	output reg  [7:0]   o_parallel_data_port,
	output reg          o_parallel_data_oe,
	input  wire         i_spi_sck,
	input  wire         i_spi_ss_n,
	input  wire         i_spi_mosi,
	output reg          o_spi_miso,
	output reg          o_spi_miso_oe,
	output reg          o_busy_indicator_pin,
	output reg  [7:0]   o_lock_bits,
	output reg  [7:0]   o_user_fuses
);
	// Two-stage synchronisers; every pin is asynchronous to i_clock
	reg [1:0] s_sel_r;
	reg [1:0] s_stb_r;
	reg [1:0] s_sck_r;
	reg [1:0] s_ss_r;
	reg [1:0] s_mosi_r;
	reg [7:0] s_d1_r;
	reg [7:0] s_d2_r;
	// Delayed copies of the synchronised levels, for edge finding
	reg       stb_q_r;
	reg       sck_q_r;
	reg       ss_q_r;
	// The data bus goes through the same two stages as the strobe,
	// so the byte seen at a strobe edge is the one set up before it.
	// The programmer must hold data for a few clocks past the rise,
	// otherwise a late change could be taken instead of the byte.
	// Edge flops are not reset: the reset spell flushes them, and
	// the decoder is held in reset while they settle.
	always @(posedge i_clock) begin
		s_sel_r  <= {s_sel_r[0], i_select_pin_n};
		s_stb_r  <= {s_stb_r[0], i_parallel_strobe};
		s_sck_r  <= {s_sck_r[0], i_spi_sck};
		s_ss_r   <= {s_ss_r[0], i_spi_ss_n};
		s_mosi_r <= {s_mosi_r[0], i_spi_mosi};
		s_d1_r   <= i_parallel_data_port;
		s_d2_r   <= s_d1_r;
		stb_q_r  <= s_stb_r[1];
		sck_q_r  <= s_sck_r[1];
		ss_q_r   <= s_ss_r[1];
	end
	wire sel_n   = s_sel_r[1];
	wire stb_rise = s_stb_r[1] & ~stb_q_r;
	wire stb_fall = ~s_stb_r[1] & stb_q_r;
	wire sck_rise = s_sck_r[1] & ~sck_q_r;
	wire sck_fall = ~s_sck_r[1] & sck_q_r;
	wire ss_n    = s_ss_r[1];
	wire ss_rise = ss_n & ~ss_q_r;

	// Serial enable is latched once, on the first clock after each reset
	// A fuse write made inside a session does not reach the link;
	// a new reset reloads FPCP_FUSE_RST, so the write is never picked up.
	// Fuse bit low means the serial link is allowed.
	reg       ser_en_r;
	reg       ser_cap_r;
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			ser_cap_r <= 1'b0;
			ser_en_r  <= 1'b0;
		end else if (!ser_cap_r) begin
			ser_cap_r <= 1'b1;
			ser_en_r  <= ~o_user_fuses[`FPCP_SERFUSE_B]; // RULE16
		end
	end

	// Serial shifter, MSB first, sample on SCK rise
	// The bit counter clears while SS is high, so a frame that is
	// cut short restarts cleanly at bit 7 of the next byte.
	reg [7:0] sh_in_r;
	reg [7:0] sh_out_r;
	reg [2:0] bit_r;
	reg       ser_byte_r;
	wire      ser_act = ser_en_r & ~ss_n & sel_n;
	always @(posedge i_clock) begin
		ser_byte_r <= 1'b0;
		if (!i_reset_n || ss_n) begin
			bit_r <= 3'h0;
		end else if (ser_act && sck_rise) begin
			sh_in_r <= {sh_in_r[6:0], s_mosi_r[1]}; // RULE18 RULE19
			bit_r   <= bit_r + 3'h1;
			if (bit_r == 3'h7)
				ser_byte_r <= 1'b1;
		end
	end

	// Two-entry byte buffer between link front ends and decoder
	reg  [7:0] fb_d_r [0:1];
	reg  [1:0] fb_v_r;
	reg        fb_wp_r;
	reg        fb_rp_r;
	// Both links feed one queue; a serial byte wins a shared cycle,
	// which cannot happen while the parallel select is low.
	// The decoder takes a byte every clock, the queue is a margin.
	wire       fb_in_v = ser_byte_r | (~sel_n & stb_rise);
	wire [7:0] fb_in_d = ser_byte_r ? sh_in_r : s_d2_r;
	wire       fb_full = fb_v_r[fb_wp_r];
	wire       fb_out_v = fb_v_r[fb_rp_r];
	wire [7:0] fb_out_d = fb_d_r[fb_rp_r];
	reg        fb_rdy;
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			fb_v_r  <= 2'b00;
			fb_wp_r <= 1'b0;
			fb_rp_r <= 1'b0;
		end else begin
			if (fb_in_v && !fb_full) begin
				fb_d_r[fb_wp_r] <= fb_in_d;
				fb_v_r[fb_wp_r] <= 1'b1;
				fb_wp_r         <= ~fb_wp_r;
			end
			if (fb_out_v && fb_rdy) begin
				fb_v_r[fb_rp_r] <= 1'b0;
				fb_rp_r         <= ~fb_rp_r;
			end
		end
	end

	// Decoder states
	// Preamble, opcode, two address bytes, then data or read-out.
	// Skip swallows a refused or unknown command up to its end.
	localparam ST_PRE  = 3'h0;
	localparam ST_OP   = 3'h1;
	localparam ST_A1   = 3'h2;
	localparam ST_A2   = 3'h3;
	localparam ST_DAT  = 3'h4;
	localparam ST_RD   = 3'h5;
	localparam ST_SKIP = 3'h6;
	reg [2:0] st_r, st_nxt;
	reg [7:0] op_r;
	reg       enabled_r;
	reg [4:0] ofs_r;
	reg [7:0] rdat;
	reg [SIG_W*32-1:0] usig_r;
	reg [23:0] wcnt_r;
	reg        pend_r;
	reg [7:0]  wdat_r;
	wire busy = (wcnt_r != 24'h0);
	reg  sel_q_r;
	// A command ends on the rise of either select; a write is only
	// started there, so a cut command never writes anything.
	always @(posedge i_clock)
		sel_q_r <= sel_n;
	wire term = (sel_n & ~sel_q_r) | ss_rise; // RULE20

	// Read data mux; the maker row returns its own offset, a plain
	// stand-in pattern that lets a reader see the offset walk.
	// Status bit 0 shows the write cycle in progress.
	always @* begin
		rdat = 8'h00;
		case (op_r)
		`FPCP_OP_USIG: rdat = usig_r[ofs_r*8 +: 8];
		`FPCP_OP_MSIG: rdat = {3'h0, ofs_r};
		`FPCP_OP_RLOCK: rdat = o_lock_bits; // RULE10
		`FPCP_OP_RFUSE: rdat = o_user_fuses; // RULE13
		`FPCP_OP_STAT: rdat = {7'h00, busy}; // RULE14
		default: rdat = 8'h00;
		endcase
	end

	// Command decode; until the enable pair has been seen, every
	// opcode but the enable one is refused, so nothing is written.
	// Unknown opcodes fall into skip and leave stored state alone.
	always @* begin
		st_nxt = st_r;
		fb_rdy = 1'b1;
		case (st_r)
		ST_PRE: if (fb_out_v)
			st_nxt = (fb_out_d == `FPCP_PREAMBLE) ? ST_OP : ST_SKIP; // RULE2
		ST_OP: if (fb_out_v) begin
			if (!enabled_r && fb_out_d != `FPCP_EN1)
				st_nxt = ST_SKIP; // RULE1
			else case (fb_out_d)
			`FPCP_EN1, `FPCP_OP_USIG, `FPCP_OP_MSIG, `FPCP_OP_WLOCK,
			`FPCP_OP_RLOCK, `FPCP_OP_WFUSE, `FPCP_OP_RFUSE,
			`FPCP_OP_STAT: st_nxt = ST_A1; // RULE3 RULE4 RULE15
			default: st_nxt = ST_SKIP; // RULE25
			endcase
		end
		ST_A1: if (fb_out_v)
			st_nxt = (op_r == `FPCP_EN1) ? ST_SKIP : ST_A2;
		ST_A2: if (fb_out_v)
			st_nxt = (op_r == `FPCP_OP_WLOCK || op_r == `FPCP_OP_WFUSE)
			         ? ST_DAT : ST_RD; // RULE9 RULE11
		ST_DAT: if (fb_out_v)
			st_nxt = ST_SKIP;
		ST_RD: st_nxt = ST_RD;
		ST_SKIP: st_nxt = ST_SKIP;
		default: st_nxt = ST_PRE;
		endcase
		if (term)
			st_nxt = ST_PRE;
	end

	always @(posedge i_clock) begin
		if (!i_reset_n || !i_prog_session) begin
			st_r      <= ST_PRE;
			op_r      <= 8'h00;
			enabled_r <= 1'b0; // RULE1
			ofs_r     <= 5'h00;
			pend_r    <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (fb_out_v && st_r == ST_OP)
				op_r <= fb_out_d;
			if (fb_out_v && st_r == ST_A1 && op_r == `FPCP_EN1 &&
			    fb_out_d == `FPCP_EN2)
				enabled_r <= 1'b1;
			if (fb_out_v && st_r == ST_A2)
				ofs_r <= fb_out_d[4:0]; // RULE5
			else if (st_r == ST_RD && !sel_n && stb_fall && stb_q_r &&
			         o_parallel_data_oe)
				ofs_r <= ofs_r + 5'h01; // RULE5 RULE8
			if (fb_out_v && st_r == ST_DAT) begin
				wdat_r <= fb_out_d;
				pend_r <= 1'b1;
			end
			if (term)
				pend_r <= 1'b0;
		end
	end

	// Nonvolatile write cycle starts when the command is closed.
	// A close that arrives while busy is ignored, so a second
	// write during the cycle is lost; the programmer must wait.
	// Lock bits only ever go from unlocked to locked here.
	// Over the serial link the serial fuse bit may be set to one
	// (link off) but never cleared back to zero.
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			wcnt_r       <= 24'h0;
			o_lock_bits  <= `FPCP_LOCK_RST;
			o_user_fuses <= `FPCP_FUSE_RST;
			usig_r       <= {(SIG_W*32){1'b1}};
		end else if (busy) begin
			wcnt_r <= wcnt_r - 24'h1;
		end else if (term && pend_r && !busy) begin
			wcnt_r <= WR_CYCLES[23:0]; // RULE24
			if (op_r == `FPCP_OP_WLOCK)
				o_lock_bits <= o_lock_bits & (wdat_r | ~`FPCP_LOCK_MASK);
			else if (ss_rise)
				o_user_fuses <= {wdat_r[7:1],
				                 o_user_fuses[0] | wdat_r[0]}; // RULE17
			else
				o_user_fuses <= wdat_r;
		end
	end

	// Outputs: parallel read drive, serial MISO, busy.
	// The port is driven only after the fall that ends the address
	// byte, so a programmer still driving it meets no contention.
	// MISO moves on the SCK fall and is steady at the next rise.
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_parallel_data_port <= 8'h00;
			o_parallel_data_oe   <= 1'b0;
			o_spi_miso           <= 1'b0;
			o_spi_miso_oe        <= 1'b0;
			o_busy_indicator_pin <= 1'b1;
			sh_out_r             <= 8'h00;
		end else begin
			o_busy_indicator_pin <= ~busy; // RULE24
			if (sel_n || st_r != ST_RD)
				o_parallel_data_oe <= 1'b0;
			else if (stb_fall && !sel_n)
				o_parallel_data_oe <= 1'b1; // RULE6
			o_parallel_data_port <= rdat; // RULE8
			o_spi_miso_oe <= ser_act;
			if (ser_act && sck_fall) begin
				if (bit_r == 3'h0 && st_r == ST_RD)
					sh_out_r <= {rdat[6:0], 1'b0};
				else
					sh_out_r <= {sh_out_r[6:0], 1'b0};
				o_spi_miso <= (bit_r == 3'h0 && st_r == ST_RD) ?
				              rdat[7] : sh_out_r[7]; // RULE18 RULE19
			end
		end
	end
endmodule

/* File: tb/fpcp_port_props.sv */
// Property checker for the flash program command port
`timescale 1ns/1ps
module fpcp_port_props #(
	parameter WR_CYCLES = 50,
	parameter SIG_W     = 8
) (
	input wire       i_clock,
	input wire       i_reset_n,
	input wire       i_prog_session,
	input wire       i_select_pin_n,
	input wire       i_parallel_strobe,
	input wire       i_spi_ss_n,
	input wire       o_parallel_data_oe,
	input wire       o_spi_miso_oe,
	input wire       o_busy_indicator_pin,
	input wire [7:0] o_lock_bits,
	input wire [7:0] o_user_fuses
);
	reg [31:0] low_cnt_r;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	// Length of the current busy spell
	always @(posedge i_clock) begin
		if (!i_reset_n || o_busy_indicator_pin)
			low_cnt_r <= 32'h0;
		else
			low_cnt_r <= low_cnt_r + 32'h1;
	end
	AST_OE_LATE: assert property (
		$rose(o_parallel_data_oe) |-> !i_parallel_strobe && !i_select_pin_n)
		else $error("port driven too early");
	AST_OE_DROP: assert property (
		$rose(i_select_pin_n) |-> ##[1:8] !o_parallel_data_oe)
		else $error("port held after select");
	AST_NO_SESSION: assert property (
		!i_prog_session [*4] |-> !o_parallel_data_oe)
		else $error("port driven outside session");
	AST_MISO_IDLE: assert property (
		i_spi_ss_n [*6] |-> !o_spi_miso_oe)
		else $error("serial output without select");
	AST_BUSY_CAUSE: assert property (
		$fell(o_busy_indicator_pin) |-> i_select_pin_n && i_spi_ss_n)
		else $error("busy inside a command");
	AST_BUSY_MAX: assert property (
		low_cnt_r <= WR_CYCLES + 4)
		else $error("busy too long");
	AST_BUSY_MIN: assert property (
		$rose(o_busy_indicator_pin) |-> low_cnt_r >= WR_CYCLES - 4)
		else $error("busy too short");
	AST_LOCK_HOLD: assert property (
		$changed(o_lock_bits) |-> i_select_pin_n)
		else $error("lock bits changed mid command");
	AST_FUSE_HOLD: assert property (
		$changed(o_user_fuses) |-> i_select_pin_n ##1 !o_busy_indicator_pin)
		else $error("fuses changed outside a write");
	cover property ($rose(o_parallel_data_oe));
	cover property ($fell(o_busy_indicator_pin));
	cover property ($changed(o_user_fuses));
endmodule
bind fpcp_port fpcp_port_props #(.WR_CYCLES(WR_CYCLES), .SIG_W(SIG_W))
	props_u (.i_clock, .i_reset_n, .i_prog_session, .i_select_pin_n,
	.i_parallel_strobe, .i_spi_ss_n, .o_parallel_data_oe, .o_spi_miso_oe,
	.o_busy_indicator_pin, .o_lock_bits, .o_user_fuses);

/* File: tb/fpcp_prog.sv */
// Programmer model for the parallel command link
`timescale 1ns/1ps
`include "fpcp_defs.vh"
module fpcp_prog (
	input  wire       i_clock,
	output reg        o_sel_n,
	output reg        o_strobe,
	output reg  [7:0] o_data,
	output reg        o_drive
);
	// Idle levels
	initial begin
		o_sel_n = 1'b1;
		o_strobe = 1'b0;
		o_data = 8'h00;
		o_drive = 1'b1;
	end
	// Step n edges, then just off the edge
	task tick(input integer n);
		begin
			repeat (n) @(posedge i_clock);
			#1;
		end
	endtask
	// One strobe pulse; a read lets go of the port before the fall
	task pulse(input [7:0] b, input rel);
		begin
			o_data = b;
			if (!rel)
				o_drive = 1'b1;
			o_strobe = 1'b1;
			tick(6);
			if (rel)
				o_drive = 1'b0;
			tick(2);
			o_strobe = 1'b0;
			tick(8);
		end
	endtask
	// Select low, then the preamble
	task go;
		begin
			o_sel_n = 1'b0;
			tick(3);
			pulse(`FPCP_PREAMBLE, 1'b0);
		end
	endtask
	// Select high ends the command
	task fin;
		begin
			o_sel_n = 1'b1;
			tick(8);
		end
	endtask
endmodule

/* File: tb/flash_program_command_port_test.sv */
// Self-checking bench for the flash program command port
`timescale 1ns/1ps
`include "fpcp_defs.vh"
`define CMP(a, e) begin checked = checked + 1; if ((a) !== (e)) begin \
	n_fail = n_fail + 1; $display("wrong value at %0t: %h not %h", \
	$time, a, e); end end
module flash_program_command_port_test;
	localparam WRC = 200;
	reg        i_clock, i_reset_n, sess, sck, ss_n, mosi;
	wire       sel_n, strb, drv, oe, miso_oe, busy;
	wire [7:0] pd, dout, lock, fuse;
	wire [7:0] port = oe ? dout : (drv ? pd : ~pd);
	integer    n_fail = 0;
	integer    checked = 0;
	integer    i;
	fpcp_prog pg (.i_clock(i_clock), .o_sel_n(sel_n), .o_strobe(strb),
		.o_data(pd), .o_drive(drv));
	fpcp_port #(.WR_CYCLES(WRC)) dut_u (.i_clock(i_clock),
		.i_reset_n(i_reset_n), .i_prog_session(sess),
		.i_select_pin_n(sel_n), .i_parallel_strobe(strb),
		.i_parallel_data_port(port), .o_parallel_data_port(dout),
		.o_parallel_data_oe(oe), .i_spi_sck(sck), .i_spi_ss_n(ss_n),
		.i_spi_mosi(mosi), .o_spi_miso(), .o_spi_miso_oe(miso_oe),
		.o_busy_indicator_pin(busy), .o_lock_bits(lock),
		.o_user_fuses(fuse));
	// 25 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	task give_verdict;
		begin
			if (n_fail == 0 && checked > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	// Read: preamble, opcode, zero, offset, then port released
	task rd4(input [7:0] op, input [7:0] off);
		begin
			pg.go;
			pg.pulse(op, 1'b0);
			pg.pulse(8'h00, 1'b0);
			pg.pulse(off, 1'b1);
		end
	endtask
	// Write: preamble, opcode, two zeros, data, select high
	task wr5(input [7:0] op, input [7:0] d);
		begin
			rd4(op, 8'h00);
			pg.pulse(d, 1'b0);
			pg.fin;
		end
	endtask
	// Wait at most n cycles for busy to reach v
	task wbusy(input v, input integer n);
		for (i = 0; i < n && busy !== v; i = i + 1)
			pg.tick(1);
	endtask
	// One serial byte, MSB first; SCK moves only inside the frame
	task ser(input [7:0] b);
		begin
			ss_n = 1'b0;
			#400;
			for (i = 7; i >= 0; i = i - 1) begin
				mosi = b[i];
				#160 sck = 1'b1;
				#160 sck = 1'b0;
			end
			`CMP(miso_oe, 1'b0)
			ss_n = 1'b1;
		end
	endtask
	// Hang guard
	initial begin
		#1000000;
		n_fail = n_fail + 1;
		give_verdict;
	end
	// Command sequence
	initial begin
		i_reset_n = 1'b0;
		sess = 1'b0;
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
		pg.tick(5);
		i_reset_n = 1'b1;
		pg.tick(6);
		sess = 1'b1;
		rd4(`FPCP_OP_RLOCK, 8'h00);
		`CMP(oe, 1'b0)
		pg.fin;
		pg.go;
		pg.pulse(`FPCP_EN1, 1'b0);
		pg.pulse(`FPCP_EN2, 1'b0);
		pg.fin;
		rd4(`FPCP_OP_RLOCK, 8'h00);
		`CMP(port, `FPCP_LOCK_RST)
		pg.fin;
		rd4(`FPCP_OP_RFUSE, 8'h00);
		`CMP(port, `FPCP_FUSE_RST)
		pg.fin;
		rd4(`FPCP_OP_USIG, 8'h1F);
		`CMP(oe, 1'b1)
		pg.fin;
		rd4(`FPCP_OP_MSIG, 8'hFE);
		for (i = 0; i < 3; i = i + 1) begin
			`CMP(port, (8'h1E + i) & 8'h1F)
			pg.pulse(8'h00, 1'b1);
		end
		pg.fin;
		wr5(`FPCP_OP_WLOCK, 8'hFC);
		wbusy(1'b0, 20);
		`CMP(busy, 1'b0)
		rd4(`FPCP_OP_STAT, 8'h00);
		`CMP(port[`FPCP_STAT_BUSY], 1'b1)
		pg.fin;
		wbusy(1'b1, WRC + 20);
		`CMP(lock, 8'hFC)
		wr5(`FPCP_OP_WFUSE, 8'hFE);
		wbusy(1'b0, 20);
		wbusy(1'b1, WRC + 20);
		`CMP(fuse, 8'hFE)
		wr5(8'h77, 8'h00);
		wbusy(1'b0, 20);
		`CMP({busy, lock, fuse}, {1'b1, 8'hFC, 8'hFE})
		ser(`FPCP_EN1);
		give_verdict;
	end
endmodule
